// File: hw/evs_pkg.sv
// Package with constants and types for the exception vector select block.
package evs_pkg;

  localparam logic [19:0] VEC_EXT      = 20'h00500;
  localparam logic [19:0] VEC_DEC      = 20'h00900;
  localparam logic [19:0] VEC_SYSCALL  = 20'h00c00;
  localparam logic [19:0] VEC_TRACE    = 20'h00d00;
  localparam logic [19:0] VEC_RESERVED = 20'h00e00;
  localparam logic [19:0] VEC_ITMISS   = 20'h01000;
  localparam logic [19:0] VEC_DLMISS   = 20'h01100;
  localparam logic [19:0] VEC_DSMISS   = 20'h01200;
  localparam logic [19:0] VEC_INSN_BREAKPOINT_ADDRESS     = 20'h01300;
  localparam logic [19:0] VEC_SMI      = 20'h01400;

  // Register byte offsets on the bus.
  localparam logic [7:0] OFS_INSN_BREAKPOINT_ADDRESS    = 8'h00;
  localparam logic [7:0] OFS_MSR     = 8'h04;
  localparam logic [7:0] OFS_DEC     = 8'h08;
  localparam logic [7:0] OFS_STATUS  = 8'h0c;
  localparam logic [7:0] OFS_IRQ_EN  = 8'h10;
  localparam logic [7:0] OFS_IRQ_CLR = 8'h14;

  // Field positions.
  localparam int INSN_BREAKPOINT_ADDRESS_EN_BIT = 1;
  localparam int MSR_EE_BIT  = 15;
  localparam int MSR_SE_BIT  = 10;
  localparam int MSR_BE_BIT  = 9;
  localparam int NUM_EXC     = 9;

  localparam logic [31:0] RST_INSN_BREAKPOINT_ADDRESS = 32'h0000_0000;
  localparam logic [31:0] RST_MSR  = 32'h0000_0000;
  localparam logic [31:0] RST_DEC  = 32'h7fff_ffff;

  // Exception index order is also the priority order, lowest index wins.
  typedef enum logic [3:0] {
    EXC_INSN_BREAKPOINT_ADDRESS, EXC_ITMISS, EXC_SMI, EXC_EXT, EXC_DEC,
    EXC_SYSCALL, EXC_DLMISS, EXC_DSMISS, EXC_TRACE
  } evs_exc_t;

  typedef struct packed {
    logic        valid;
    logic [29:0] addr;
    logic        is_branch;
    logic        is_syscall;
  } evs_compl_t;

  typedef struct packed {
    logic itc_miss;
    logic dtc_load_miss;
    logic dtc_store_miss;
    logic dtc_store_chg;
  } evs_xlate_t;

endpackage : evs_pkg

// File: hw/evs_sticky_bit.sv
// One sticky status flag where a set beats a clear in the same cycle.
`timescale 1ns/1ps
module evs_sticky_bit (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic set,
  input  wire logic clr,
  output logic      flag_r
);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      flag_r <= 1'b0;
    else if (set)
      flag_r <= 1'b1;
    else if (clr)
      flag_r <= 1'b0;
  end

endmodule : evs_sticky_bit

// File: hw/evs_top.sv
// Exception vector select with an AHB-Lite register slave.
//
// The AHB-Lite interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module evs_top (
  input  wire logic               hclk,
  input  wire logic               hresetn,
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic      [31:0]        hrdata,
  output logic                    hreadyout,
  output logic                    hresp,
  input  wire evs_pkg::evs_compl_t compl,
  input  wire evs_pkg::evs_xlate_t xlate,
  input  wire logic               ext_int_n,
  input  wire logic               sys_mgmt_int_n,
  output logic                    exc_take_r,
  output logic      [19:0]        exc_vector_r,
  output logic                    irq_r
);

  localparam int N = evs_pkg::NUM_EXC;

  logic [31:0]  insn_breakpoint_address_r;
  logic [31:0]  machine_state_reg_r;
  logic [31:0]  decrement_counter_r;
  logic         dec_msb_prev_r;
  logic         dec_pend_r;
  logic [N-1:0] irq_en_r;
  logic [N-1:0] status;
  logic [N-1:0] cond;
  logic [N-1:0] clr_bits;
  logic         wr_pend_r;
  logic [7:0]   wr_addr_r;
  logic         ee;
  logic         hit;
  logic         clr_wr;
  logic         exc_take_nxt;
  logic [19:0]  exc_vector_nxt;

  assign ee = machine_state_reg_r[evs_pkg::MSR_EE_BIT];

  // Bus address phase capture; the slave is always ready with zero wait states.
  assign hit = hsel && hready && htrans[1];

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
    end
    else
    begin
      wr_pend_r <= hit && hwrite;
      if (hit)
        wr_addr_r <= haddr[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // Read data is registered in the address phase so it stands in the data phase.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (hit && !hwrite)
    begin
      case (haddr[7:0])
        evs_pkg::OFS_INSN_BREAKPOINT_ADDRESS:   hrdata <= insn_breakpoint_address_r;
        evs_pkg::OFS_MSR:    hrdata <= machine_state_reg_r;
        evs_pkg::OFS_DEC:    hrdata <= decrement_counter_r;
        evs_pkg::OFS_STATUS: hrdata <= {23'h000000, status};
        evs_pkg::OFS_IRQ_EN: hrdata <= {23'h000000, irq_en_r};
        default:             hrdata <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      insn_breakpoint_address_r <= evs_pkg::RST_INSN_BREAKPOINT_ADDRESS;
      machine_state_reg_r       <= evs_pkg::RST_MSR;
      irq_en_r                  <= '0;
    end
    else if (wr_pend_r)
    begin
      case (wr_addr_r)
        evs_pkg::OFS_INSN_BREAKPOINT_ADDRESS:   insn_breakpoint_address_r <= hwdata;
        evs_pkg::OFS_MSR:    machine_state_reg_r       <= hwdata;
        evs_pkg::OFS_IRQ_EN: irq_en_r                  <= hwdata[N-1:0];
        default:             ;
      endcase
    end
  end

  // The counter decrements every cycle; software may reload it.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      decrement_counter_r <= evs_pkg::RST_DEC;
    else if (wr_pend_r && wr_addr_r == evs_pkg::OFS_DEC)
      decrement_counter_r <= hwdata;
    else
      decrement_counter_r <= decrement_counter_r - 32'h0000_0001;
  end

  // A 0 to 1 edge of the counter top bit is held pending until the decrementer vector is selected.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dec_msb_prev_r <= 1'b0;
      dec_pend_r     <= 1'b0;
    end
    else
    begin
      dec_msb_prev_r <= decrement_counter_r[31];
      if (!dec_msb_prev_r && decrement_counter_r[31])
        dec_pend_r <= 1'b1;
      else if (exc_take_nxt && cond[evs_pkg::EXC_DEC] && ee &&
               exc_vector_nxt == evs_pkg::VEC_DEC)
        dec_pend_r <= 1'b0;
    end
  end

  always_comb
  begin
    cond = '0;
    cond[evs_pkg::EXC_INSN_BREAKPOINT_ADDRESS]    = compl.valid &&
                                 insn_breakpoint_address_r[evs_pkg::INSN_BREAKPOINT_ADDRESS_EN_BIT] &&
                                 insn_breakpoint_address_r[31:2] == compl.addr;
    cond[evs_pkg::EXC_ITMISS]  = xlate.itc_miss;
    cond[evs_pkg::EXC_SMI]     = ee && !sys_mgmt_int_n;
    cond[evs_pkg::EXC_EXT]     = ee && !ext_int_n;
    cond[evs_pkg::EXC_DEC]     = ee && dec_pend_r;
    cond[evs_pkg::EXC_SYSCALL] = compl.valid && compl.is_syscall;
    cond[evs_pkg::EXC_DLMISS]  = xlate.dtc_load_miss;
    cond[evs_pkg::EXC_DSMISS]  = xlate.dtc_store_miss || xlate.dtc_store_chg;
    cond[evs_pkg::EXC_TRACE]   = compl.valid &&
                                 (machine_state_reg_r[evs_pkg::MSR_SE_BIT] ||
                                  (compl.is_branch &&
                                   machine_state_reg_r[evs_pkg::MSR_BE_BIT]));
  end

  // Fixed priority: lowest index of the exception enumeration wins.
  always_comb
  begin
    exc_take_nxt   = 1'b0;
    exc_vector_nxt = 20'h00000;
    if (cond[evs_pkg::EXC_INSN_BREAKPOINT_ADDRESS])           exc_vector_nxt = evs_pkg::VEC_INSN_BREAKPOINT_ADDRESS;
    else if (cond[evs_pkg::EXC_ITMISS])    exc_vector_nxt = evs_pkg::VEC_ITMISS;
    else if (cond[evs_pkg::EXC_SMI])       exc_vector_nxt = evs_pkg::VEC_SMI;
    else if (cond[evs_pkg::EXC_EXT])       exc_vector_nxt = evs_pkg::VEC_EXT;
    else if (cond[evs_pkg::EXC_DEC])       exc_vector_nxt = evs_pkg::VEC_DEC;
    else if (cond[evs_pkg::EXC_SYSCALL])   exc_vector_nxt = evs_pkg::VEC_SYSCALL;
    else if (cond[evs_pkg::EXC_DLMISS])    exc_vector_nxt = evs_pkg::VEC_DLMISS;
    else if (cond[evs_pkg::EXC_DSMISS])    exc_vector_nxt = evs_pkg::VEC_DSMISS;
    else if (cond[evs_pkg::EXC_TRACE])     exc_vector_nxt = evs_pkg::VEC_TRACE;
    exc_take_nxt = |cond;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      exc_take_r   <= 1'b0;
      exc_vector_r <= 20'h00000;
    end
    else
    begin
      exc_take_r   <= exc_take_nxt;
      exc_vector_r <= exc_vector_nxt;
    end
  end

  assign clr_wr   = wr_pend_r && wr_addr_r == evs_pkg::OFS_IRQ_CLR;
  assign clr_bits = clr_wr ? hwdata[N-1:0] : '0;

  genvar gi;
  generate
    for (gi = 0; gi < N; gi++)
    begin : g_sticky
      evs_sticky_bit u_bit (
        .hclk    (hclk),
        .hresetn (hresetn),
        .set     (cond[gi]),
        .clr     (clr_bits[gi]),
        .flag_r  (status[gi])
      );
    end
  endgenerate

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      irq_r <= 1'b0;
    else
      irq_r <= |(status & irq_en_r);
  end

  a_vec_match: assert property (@(posedge hclk) disable iff (!hresetn)
    exc_take_nxt |=> exc_take_r && exc_vector_r == $past(exc_vector_nxt))
    else $error("Vector not presented one cycle after selection.");
  a_no_e00: assert property (@(posedge hclk) disable iff (!hresetn)
    exc_vector_r != evs_pkg::VEC_RESERVED)
    else $error("Reserved vector produced.");
  a_dec_edge: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(decrement_counter_r[31]) |=> dec_pend_r)
    else $error("Counter top bit edge not caught.");
  a_dec_gated: assert property (@(posedge hclk) disable iff (!hresetn)
    (!ee && !cond[evs_pkg::EXC_EXT]) |=> exc_vector_r != evs_pkg::VEC_DEC)
    else $error("Decrementer taken while disabled.");
  a_sys_call: assert property (@(posedge hclk) disable iff (!hresetn)
    (compl.valid && compl.is_syscall && cond[4:0] == '0) |=>
      exc_vector_r == evs_pkg::VEC_SYSCALL)
    else $error("System call vector missing.");
  a_itc_miss: assert property (@(posedge hclk) disable iff (!hresetn)
    (xlate.itc_miss && !cond[evs_pkg::EXC_INSN_BREAKPOINT_ADDRESS]) |=>
      exc_vector_r == evs_pkg::VEC_ITMISS)
    else $error("Instruction miss vector missing.");
  a_insn_breakpoint_address_off: assert property (@(posedge hclk) disable iff (!hresetn)
    !insn_breakpoint_address_r[evs_pkg::INSN_BREAKPOINT_ADDRESS_EN_BIT] |=>
      exc_vector_r != evs_pkg::VEC_INSN_BREAKPOINT_ADDRESS)
    else $error("Breakpoint fired while disabled.");
  a_smi_gated: assert property (@(posedge hclk) disable iff (!hresetn)
    !ee |=> exc_vector_r != evs_pkg::VEC_SMI)
    else $error("Management interrupt taken while disabled.");
  a_store_chg: assert property (@(posedge hclk) disable iff (!hresetn)
    (xlate.dtc_store_chg && cond[6:0] == '0) |=>
      exc_vector_r == evs_pkg::VEC_DSMISS)
    else $error("Change bit store miss missing.");
  a_store_miss: assert property (@(posedge hclk) disable iff (!hresetn)
    (xlate.dtc_store_miss && cond[6:0] == '0) |=>
      exc_vector_r == evs_pkg::VEC_DSMISS)
    else $error("Store miss vector missing.");
  a_load_miss: assert property (@(posedge hclk) disable iff (!hresetn)
    (xlate.dtc_load_miss && cond[5:0] == '0) |=>
      exc_vector_r == evs_pkg::VEC_DLMISS)
    else $error("Load miss vector missing.");
  a_ext_taken: assert property (@(posedge hclk) disable iff (!hresetn)
    (ee && !ext_int_n && cond[2:0] == '0) |=> exc_vector_r == evs_pkg::VEC_EXT)
    else $error("External interrupt vector missing.");
  a_smi_taken: assert property (@(posedge hclk) disable iff (!hresetn)
    (ee && !sys_mgmt_int_n && cond[1:0] == '0) |=> exc_vector_r == evs_pkg::VEC_SMI)
    else $error("Management interrupt vector missing.");
  a_insn_breakpoint_address_hit: assert property (@(posedge hclk) disable iff (!hresetn)
    (compl.valid && insn_breakpoint_address_r[evs_pkg::INSN_BREAKPOINT_ADDRESS_EN_BIT] &&
     insn_breakpoint_address_r[31:2] == compl.addr) |=>
      exc_vector_r == evs_pkg::VEC_INSN_BREAKPOINT_ADDRESS)
    else $error("Breakpoint vector missing.");
  a_trace_step: assert property (@(posedge hclk) disable iff (!hresetn)
    (compl.valid && machine_state_reg_r[evs_pkg::MSR_SE_BIT] && cond[7:0] == '0) |=>
      exc_vector_r == evs_pkg::VEC_TRACE)
    else $error("Single step trace vector missing.");
  a_dec_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    (exc_vector_nxt == evs_pkg::VEC_DEC &&
     (dec_msb_prev_r || !decrement_counter_r[31])) |=> !dec_pend_r)
    else $error("Decrementer stayed pending after being taken.");
  a_idle_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    !exc_take_nxt |=> !exc_take_r && exc_vector_r == 20'h00000)
    else $error("Vector shown with no exception selected.");

  c_smi: cover property (@(posedge hclk) disable iff (!hresetn)
    exc_vector_r == evs_pkg::VEC_SMI);
  c_dec: cover property (@(posedge hclk) disable iff (!hresetn)
    exc_vector_r == evs_pkg::VEC_DEC);
  c_trace: cover property (@(posedge hclk) disable iff (!hresetn)
    exc_vector_r == evs_pkg::VEC_TRACE);
  c_irq: cover property (@(posedge hclk) disable iff (!hresetn) irq_r);
  c_ext: cover property (@(posedge hclk) disable iff (!hresetn)
    exc_vector_r == evs_pkg::VEC_EXT);

endmodule : evs_top

// File: verif/evs_irq_src.sv
// Model of the interrupt sources that drive the two request pins.
`timescale 1ns/1ps
module evs_irq_src (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic ext_req,
  input  wire logic smi_req,
  input  wire logic smi_ack,
  output logic      ext_int_n,
  output logic      sys_mgmt_int_n
);
  assign ext_int_n = !ext_req;
  // The management request stays low until software acknowledges it.
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      sys_mgmt_int_n <= 1'b1;
    else if (smi_ack)
      sys_mgmt_int_n <= 1'b1;
    else if (smi_req)
      sys_mgmt_int_n <= 1'b0;
endmodule : evs_irq_src

// File: verif/tb.sv
// Self-checking testbench for the exception vector select block.
`timescale 1ns/1ps
module tb;
  logic                hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hready;
  logic [31:0]         haddr = 0, hwdata = 0, hrdata, q;
  logic [1:0]          htrans = 0;
  logic                hreadyout, hresp, exc_take_r, irq_r, ext_int_n, sys_mgmt_int_n;
  logic [19:0]         exc_vector_r;
  logic                ext_req = 0, smi_req = 0, smi_ack = 0;
  evs_pkg::evs_compl_t compl = '0;
  evs_pkg::evs_xlate_t xlate = '0;
  int                  miscompares = 0, num_checks = 0;
  localparam logic [31:0] EE = 32'h1 << evs_pkg::MSR_EE_BIT;
  localparam logic [31:0] BE = 32'h1 << evs_pkg::MSR_BE_BIT;
  localparam logic [31:0] SE = 32'h1 << evs_pkg::MSR_SE_BIT;
  localparam logic [29:0] BA = 30'h1234567;
  localparam logic [19:0] VECS [6] = '{evs_pkg::VEC_ITMISS, evs_pkg::VEC_DLMISS,
    evs_pkg::VEC_DSMISS, evs_pkg::VEC_DSMISS, evs_pkg::VEC_SYSCALL, evs_pkg::VEC_TRACE};

  assign hready = hreadyout;
  always #12.5 hclk = ~hclk;

  evs_top evs_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .compl(compl), .xlate(xlate),
    .ext_int_n(ext_int_n), .sys_mgmt_int_n(sys_mgmt_int_n), .exc_take_r(exc_take_r),
    .exc_vector_r(exc_vector_r), .irq_r(irq_r));
  evs_irq_src evs_irq_src_inst (.hclk(hclk), .hresetn(hresetn), .ext_req(ext_req),
    .smi_req(smi_req), .smi_ack(smi_ack), .ext_int_n(ext_int_n),
    .sys_mgmt_int_n(sys_mgmt_int_n));

  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1; htrans <= 2'h2; hwrite <= w; haddr <= {24'h0, a};
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
  endtask : bus

  task wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task rd(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk("read data", q, exp);
    chk("response", hresp, 0);
    chk("ready", hreadyout, 1);
  endtask : rd

  // Waits for the sampling edge, clears one-cycle causes and judges the result.
  task exp_exc(input logic t, input logic [19:0] v);
    @(posedge hclk);
    compl <= '0;
    xlate <= '0;
    #1;
    chk("take", exc_take_r, t);
    chk("vector", exc_vector_r, v);
    chk("reserved", exc_vector_r === evs_pkg::VEC_RESERVED, 0);
  endtask : exp_exc

  task t_ext;
    rd(evs_pkg::OFS_MSR, evs_pkg::RST_MSR);
    rd(evs_pkg::OFS_INSN_BREAKPOINT_ADDRESS, evs_pkg::RST_INSN_BREAKPOINT_ADDRESS);
    rd(8'h20, 32'h0);
    wr(evs_pkg::OFS_IRQ_CLR, 32'h1ff);
    @(posedge hclk); ext_req <= 1'b1;
    repeat (3) @(posedge hclk);
    exp_exc(0, 20'h0);
    wr(evs_pkg::OFS_MSR, EE);
    exp_exc(1, evs_pkg::VEC_EXT);
    wr(evs_pkg::OFS_IRQ_EN, 32'h8);
    rd(evs_pkg::OFS_IRQ_EN, 32'h8);
    @(posedge hclk); ext_req <= 1'b0;
    repeat (2) @(posedge hclk);
    #1 chk("irq", irq_r, 1);
    rd(evs_pkg::OFS_STATUS, 32'h8);
    wr(evs_pkg::OFS_IRQ_CLR, 32'h8);
    repeat (2) @(posedge hclk);
    #1 chk("irq", irq_r, 0);
    $display("test ext done");
  endtask : t_ext

  task t_causes;
    wr(evs_pkg::OFS_MSR, EE | BE);
    for (int i = 0; i < 6; i++)
    begin
      @(posedge hclk);
      xlate <= evs_pkg::evs_xlate_t'(4'h8 >> i);
      compl <= {i > 3, 30'h0, i == 5, i == 4};
      exp_exc(1, VECS[i]);
    end
    wr(evs_pkg::OFS_MSR, EE | SE);
    @(posedge hclk); compl <= {1'b1, 30'h0, 2'b00};
    exp_exc(1, evs_pkg::VEC_TRACE);
    wr(evs_pkg::OFS_MSR, EE);
    $display("test causes done");
  endtask : t_causes

  task t_insn_breakpoint_address;
    wr(evs_pkg::OFS_INSN_BREAKPOINT_ADDRESS, {BA, 2'b10});
    rd(evs_pkg::OFS_INSN_BREAKPOINT_ADDRESS, {BA, 2'b10});
    @(posedge hclk); compl <= {1'b1, BA, 2'b00};
    exp_exc(1, evs_pkg::VEC_INSN_BREAKPOINT_ADDRESS);
    wr(evs_pkg::OFS_INSN_BREAKPOINT_ADDRESS, {BA, 2'b00});
    @(posedge hclk); compl <= {1'b1, BA, 2'b00};
    exp_exc(0, 20'h0);
    $display("test breakpoint done");
  endtask : t_insn_breakpoint_address

  task t_smi;
    @(posedge hclk); smi_req <= 1'b1; ext_req <= 1'b1; compl <= {1'b1, 30'h0, 2'b01};
    @(posedge hclk); smi_req <= 1'b0;
    exp_exc(1, evs_pkg::VEC_SMI);
    @(posedge hclk); ext_req <= 1'b0;
    exp_exc(1, evs_pkg::VEC_SMI);
    @(posedge hclk); smi_ack <= 1'b1;
    @(posedge hclk); smi_ack <= 1'b0;
    wr(evs_pkg::OFS_MSR, 32'h0);
    @(posedge hclk); smi_req <= 1'b1;
    @(posedge hclk); smi_req <= 1'b0;
    exp_exc(0, 20'h0);
    @(posedge hclk); smi_ack <= 1'b1;
    @(posedge hclk); smi_ack <= 1'b0;
    $display("test management done");
  endtask : t_smi

  task t_dec;
    int n;
    n = 0;
    wr(evs_pkg::OFS_DEC, 32'h3);
    repeat (10) @(posedge hclk);
    exp_exc(0, 20'h0);
    wr(evs_pkg::OFS_MSR, EE);
    do
    begin
      @(posedge hclk);
      #1 n++;
    end
    while (exc_take_r !== 1'b1 && n < 20);
    chk("dec vector", exc_vector_r, evs_pkg::VEC_DEC);
    @(posedge hclk);
    #1 chk("dec once", exc_take_r, 0);
    $display("test decrementer done");
  endtask : t_dec

  task results;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : results

  initial
  begin
    #50000;
    miscompares++;
    results();
  end

  initial
  begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    t_ext();
    t_causes();
    t_insn_breakpoint_address();
    t_smi();
    t_dec();
    results();
  end
endmodule : tb
